// ### logic/uhp_pkg.sv
// Purpose: shared constants and types for the host port and channel register block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: offsets are local to this block

// ****************************************
// package
// ****************************************
package uhp_pkg;
	localparam int UHP_NCHAN = 16;
	localparam logic [7:0] UHP_OFS_PORT = 8'h00;
	localparam logic [7:0] UHP_OFS_PSTAT = 8'h04;
	localparam logic [7:0] UHP_OFS_CHAN0 = 8'h40;
	localparam logic [31:0] UHP_RST_PORT = 32'h0000_0000;
	localparam logic [31:0] UHP_RST_CHAN = 32'h0000_0000;
	localparam int UHP_B_SUSP = 7;
	localparam int UHP_B_RES = 6;
	localparam int UHP_B_OCCHG = 5;
	localparam int UHP_B_OCACT = 4;
	localparam int UHP_B_ENCHG = 3;
	localparam int UHP_B_ENA = 2;
	localparam int UHP_B_CONDET = 1;
	localparam int UHP_B_CONSTS = 0;
	localparam int UHP_B_CHANNEL_ENABLE = 31;
	localparam int UHP_B_CHANNEL_DISABLE = 30;
	localparam logic [31:0] UHP_CHAN_RW_MASK = 32'h3FFE_FFFF;
	localparam logic [31:0] UHP_CHAN_MC_MIN = 32'h0010_0000;
	localparam logic [31:0] UHP_CHAN_MC_MASK = 32'h0030_0000;

	typedef enum logic [1:0]
	{
		UHP_EP_CONTROL = 2'h0,
		UHP_EP_ISO = 2'h1,
		UHP_EP_BULK = 2'h2,
		UHP_EP_INTR = 2'h3
	} uhp_ep_t;

	typedef struct packed
	{
		logic channel_enable;
		logic channel_disable;
		logic odd_frame_select;
		logic [6:0] target_device_address;
		logic [1:0] periodic_transactions_per_frame;
		uhp_ep_t endpoint_transfer_type;
		logic low_speed_target;
		logic rsvd;
		logic endpoint_direction;
		logic [3:0] endpoint_number;
		logic [10:0] max_packet_bytes;
	} uhp_chan_t;

	typedef struct packed
	{
		logic connected;
		logic overcurrent;
		logic reset_done;
		logic wakeup;
		logic disconnect_evt;
	} uhp_line_t;
endpackage : uhp_pkg

// ### logic/uhp_regs.sv
// Purpose: host port control/status and 16 channel configuration registers
// Assumes: wishbone classic slave, one clock, sync reset
// Notes: line events come from the port engine; channel halts come from the scheduler
`timescale 1ns/1ns
module uhp_regs
	import uhp_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	// port pins, asynchronous
	input wire logic connected_i,
	input wire logic overcurrent_i,
	// port engine events, same clock
	input wire logic reset_done_i,
	input wire logic wakeup_i,
	input wire logic disconnect_i,
	// scheduler, same clock
	input wire logic [UHP_NCHAN-1:0] chan_halted_i,
	// port control outputs
	output logic port_resume_drive_o,
	output logic sof_enable_o,
	output logic port_enabled_o,
	output logic host_port_irq_o,
	// channel controls
	output logic [UHP_NCHAN-1:0] chan_run_o,
	output logic [UHP_NCHAN-1:0] chan_stop_o
);

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	function automatic logic is_chan(input logic [7:0] adr);
		is_chan = (adr >= UHP_OFS_CHAN0) && (adr < UHP_OFS_CHAN0 + 8'(UHP_NCHAN * 4)) && (adr[1:0] == 2'h0);
	endfunction : is_chan

	// ****************************************
	// bus decode
	// ****************************************
	logic req;
	logic wr;
	logic [31:0] wmask;
	logic [31:0] w1;
	logic hit_port;
	logic hit_pstat;
	logic hit_chan;
	logic [3:0] chan_idx;
	logic [7:0] chan_ofs;

	assign req = cyc_i && stb_i && !ack_o && !err_o;
	assign wr = req && we_i;
	assign wmask = lane_mask(sel_i);
	assign w1 = dat_i & wmask;
	assign hit_port = adr_i == UHP_OFS_PORT;
	assign hit_pstat = adr_i == UHP_OFS_PSTAT;
	assign hit_chan = is_chan(adr_i);
	assign chan_ofs = adr_i - UHP_OFS_CHAN0;
	assign chan_idx = chan_ofs[5:2];

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] con_sync;
	logic [2:0] oc_sync;
	logic connect_status;
	logic overcurrent_active;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			con_sync <= 3'h0;
			oc_sync <= 3'h0;
		end
		else
		begin
			con_sync <= {con_sync[1:0], connected_i};
			oc_sync <= {oc_sync[1:0], overcurrent_i};
		end
	end

	// a level counts once stages two and three agree
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			connect_status <= 1'b0;
			overcurrent_active <= 1'b0;
		end
		else
		begin
			if (con_sync[1] == con_sync[2])
				connect_status <= con_sync[2];
			if (oc_sync[1] == oc_sync[2])
				overcurrent_active <= oc_sync[2];
		end
	end

	logic connect_rise;
	logic overcurrent_edge;
	assign connect_rise = (con_sync[1] == con_sync[2]) && con_sync[2] && !connect_status;
	assign overcurrent_edge = (oc_sync[1] == oc_sync[2]) && (oc_sync[2] != overcurrent_active);

	// ****************************************
	// port state
	// ****************************************
	logic port_suspend;
	logic resume_sw;
	logic resume_hw;
	logic port_enabled;
	logic overcurrent_change_flag;
	logic enable_change_flag;
	logic connect_detected_flag;
	logic port_wr;
	logic next_port_enabled;

	assign port_wr = wr && hit_port;

	// software may only clear enable; faults also clear it
	always_comb
	begin
		next_port_enabled = port_enabled;
		if (reset_done_i)
			next_port_enabled = 1'b1;
		if (overcurrent_edge && oc_sync[2])
			next_port_enabled = 1'b0;
		if (disconnect_i)
			next_port_enabled = 1'b0;
		if (port_wr && w1[UHP_B_ENA])
			next_port_enabled = 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			port_enabled <= 1'b0;
		else
			port_enabled <= next_port_enabled;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			port_suspend <= 1'b0;
		else if (wakeup_i || (port_wr && w1[UHP_B_RES]))
			port_suspend <= 1'b0;
		else if (port_wr && w1[UHP_B_SUSP])
			port_suspend <= 1'b1;
	end

	// resume is a plain rw bit: software holds it to keep driving
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			resume_sw <= 1'b0;
		else if (port_wr && sel_i[0])
			resume_sw <= dat_i[UHP_B_RES];
	end

	// hardware resume ends once software writes the bit low
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			resume_hw <= 1'b0;
		else if (wakeup_i)
			resume_hw <= 1'b1;
		else if (port_wr && sel_i[0] && !dat_i[UHP_B_RES])
			resume_hw <= 1'b0;
	end

	// set wins over a simultaneous clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			overcurrent_change_flag <= 1'b0;
			enable_change_flag <= 1'b0;
			connect_detected_flag <= 1'b0;
		end
		else
		begin
			if (overcurrent_edge)
				overcurrent_change_flag <= 1'b1;
			else if (port_wr && w1[UHP_B_OCCHG])
				overcurrent_change_flag <= 1'b0;
			if (next_port_enabled != port_enabled)
				enable_change_flag <= 1'b1;
			else if (port_wr && w1[UHP_B_ENCHG])
				enable_change_flag <= 1'b0;
			if (connect_rise)
				connect_detected_flag <= 1'b1;
			else if (port_wr && w1[UHP_B_CONDET])
				connect_detected_flag <= 1'b0;
		end
	end

	logic [31:0] port_word;
	always_comb
	begin
		port_word = UHP_RST_PORT;
		port_word[UHP_B_SUSP] = port_suspend;
		port_word[UHP_B_RES] = resume_sw || resume_hw;
		port_word[UHP_B_OCCHG] = overcurrent_change_flag;
		port_word[UHP_B_OCACT] = overcurrent_active;
		port_word[UHP_B_ENCHG] = enable_change_flag;
		port_word[UHP_B_ENA] = port_enabled;
		port_word[UHP_B_CONDET] = connect_detected_flag;
		port_word[UHP_B_CONSTS] = connect_status;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			port_resume_drive_o <= 1'b0;
			sof_enable_o <= 1'b0;
			port_enabled_o <= 1'b0;
			host_port_irq_o <= 1'b0;
		end
		else
		begin
			port_resume_drive_o <= resume_sw || resume_hw;
			sof_enable_o <= port_enabled && !port_suspend;
			port_enabled_o <= port_enabled;
			host_port_irq_o <= connect_detected_flag || enable_change_flag || overcurrent_change_flag;
		end
	end

	// ****************************************
	// channel registers
	// ****************************************
	uhp_chan_t chan [UHP_NCHAN];
	logic [UHP_NCHAN-1:0] chan_lowspeed;

	genvar g;
	generate
		for (g = 0; g < UHP_NCHAN; g++)
		begin : g_chan
			logic hit;
			logic [31:0] merged;
			assign hit = wr && hit_chan && (chan_idx == 4'(g));
			// rw fields take the byte lanes; reserved bit stays zero
			assign merged = (chan[g] & ~(wmask & UHP_CHAN_RW_MASK)) | (dat_i & wmask & UHP_CHAN_RW_MASK);

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					chan[g] <= uhp_chan_t'(UHP_RST_CHAN);
				else
				begin
					if (hit)
						chan[g][29:0] <= merged[29:0];
					if (chan_halted_i[g])
						chan[g].channel_enable <= 1'b0;
					else if (hit && w1[UHP_B_CHANNEL_ENABLE])
						chan[g].channel_enable <= 1'b1;
					if (chan_halted_i[g])
						chan[g].channel_disable <= 1'b0;
					else if (hit && w1[UHP_B_CHANNEL_DISABLE])
						chan[g].channel_disable <= 1'b1;
				end
			end

			// a reserved multi count would be undefined; run only when legal for periodic types
			logic periodic;
			logic mc_ok;
			assign periodic = chan[g].endpoint_transfer_type == UHP_EP_ISO
				|| chan[g].endpoint_transfer_type == UHP_EP_INTR;
			assign mc_ok = !periodic || ((32'(chan[g]) & UHP_CHAN_MC_MASK) >= UHP_CHAN_MC_MIN);

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					chan_run_o[g] <= 1'b0;
					chan_stop_o[g] <= 1'b0;
					chan_lowspeed[g] <= 1'b0;
				end
				else
				begin
					chan_run_o[g] <= chan[g].channel_enable && mc_ok && port_enabled;
					chan_stop_o[g] <= chan[g].channel_disable;
					chan_lowspeed[g] <= chan[g].low_speed_target;
				end
			end
		end
	endgenerate

	// ****************************************
	// bus answer
	// ****************************************
	logic [31:0] rdata;
	always_comb
	begin
		rdata = 32'h0000_0000;
		if (hit_port)
			rdata = port_word;
		else if (hit_pstat)
			rdata = {16'h0000, chan_lowspeed};
		else if (hit_chan)
			rdata = 32'(chan[chan_idx]);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= req && (hit_port || hit_pstat || hit_chan);
			err_o <= req && !(hit_port || hit_pstat || hit_chan);
			dat_o <= (req && !we_i) ? rdata : 32'h0000_0000;
		end
	end

endmodule : uhp_regs

// ### test/uhp_dev_model.sv
// Purpose: behavioural device on the port and its port engine events
// Assumes: same clock as the register block
// Notes: halts any running or stopping channel after HALT_DLY cycles
`timescale 1ns/1ns
module uhp_dev_model
	import uhp_pkg::*;
#(
	parameter int HALT_DLY = 20
)
(
	// clock and channel demands
	input wire logic clk_i,
	input wire logic [UHP_NCHAN-1:0] chan_run_i,
	input wire logic [UHP_NCHAN-1:0] chan_stop_i,
	// line state and events
	output logic connected_o,
	output logic overcurrent_o,
	output logic reset_done_o,
	output logic wakeup_o,
	output logic disconnect_o,
	output logic [UHP_NCHAN-1:0] chan_halted_o
);
	// ****
	// model
	// ****
	int cnt = 0;
	initial
	begin
		{connected_o, overcurrent_o, reset_done_o, wakeup_o, disconnect_o} = 5'h00;
	end
	// slow answer: a stop takes effect only when the transfer winds down
	always @(posedge clk_i)
	begin
		cnt <= ((chan_run_i | chan_stop_i) == '0 || cnt == HALT_DLY) ? 0 : cnt + 1;
		chan_halted_o <= (cnt == HALT_DLY) ? (chan_run_i | chan_stop_i) : '0;
	end
	task automatic attach(input logic c, input logic o);
		@(posedge clk_i);
		connected_o <= c;
		overcurrent_o <= o;
	endtask : attach
	task automatic pulse(input logic [2:0] k);
		@(posedge clk_i);
		reset_done_o <= k[2];
		wakeup_o <= k[1];
		disconnect_o <= k[0];
		@(posedge clk_i);
		reset_done_o <= 1'b0;
		wakeup_o <= 1'b0;
		disconnect_o <= 1'b0;
	endtask : pulse
endmodule : uhp_dev_model

// ### test/uhp_regs_checker.sv
// Purpose: concurrent checks on the port and channel register block
// Assumes: one clock, synchronous reset
// Notes: sees the top ports only
`timescale 1ns/1ns
module uhp_regs_checker
	import uhp_pkg::*;
(
	// clock, reset, bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic err_o,
	// port engine
	input wire logic connected_i,
	input wire logic reset_done_i,
	input wire logic wakeup_i,
	input wire logic disconnect_i,
	input wire logic [UHP_NCHAN-1:0] chan_halted_i,
	// controls
	input wire logic port_resume_drive_o,
	input wire logic sof_enable_o,
	input wire logic port_enabled_o,
	input wire logic host_port_irq_o,
	input wire logic [UHP_NCHAN-1:0] chan_run_o,
	input wire logic [UHP_NCHAN-1:0] chan_stop_o
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_taken;
		cyc_i && stb_i && !ack_o && !err_o;
	endsequence
	sequence s_answer;
		(ack_o ^ err_o) ##1 !(ack_o || err_o);
	endsequence
	a_bus_answer: assert property (s_taken |=> s_answer) else $error("bus answer wrong");
	a_err_zero: assert property (err_o |-> dat_o == 32'h0) else $error("refused read not zero");
	a_enable_cause: assert property ($rose(port_enabled_o) |-> $past(reset_done_i, 2))
		else $error("enable without reset done");
	a_disc_off: assert property (disconnect_i && !reset_done_i |-> ##2 !port_enabled_o)
		else $error("enable kept after disconnect");
	a_sof_gate: assert property (sof_enable_o |-> port_enabled_o || $past(port_enabled_o))
		else $error("frames on disabled port");
	a_wake_resume: assert property (wakeup_i |-> ##[1:2] port_resume_drive_o)
		else $error("no resume on wakeup");
	a_conn_irq: assert property ($rose(connected_i) |-> ##[1:10] host_port_irq_o)
		else $error("no irq on connect");
	a_halt_clear: assert property (|chan_halted_i |-> ##2 ((chan_run_o | chan_stop_o) & $past(chan_halted_i, 2)) == '0)
		else $error("halt did not clear channel");
	a_run_port: assert property (chan_run_o != '0 |-> port_enabled_o || $past(port_enabled_o))
		else $error("channel runs on disabled port");
endmodule : uhp_regs_checker

// ### test/uhp_regs_test.sv
// Purpose: register level test of the port and channel block
// Assumes: classic wishbone master, device model on the port
// Notes: bus answers are taken at the rising edge that sees ack; levels are checked on the falling edge after tick, else at the rising edge that ends a bus cycle
`timescale 1ns/1ns
module uhp_regs_test;
	import uhp_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, erred;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, q, w;
	logic ack_o, err_o, connected_i, overcurrent_i, reset_done_i, wakeup_i, disconnect_i;
	logic port_resume_drive_o, sof_enable_o, port_enabled_o, host_port_irq_o;
	logic [UHP_NCHAN-1:0] chan_halted_i, chan_run_o, chan_stop_o;
	int n_mismatch = 0, checks_done = 0;
	always #5 clk_i = ~clk_i;
	uhp_regs uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o,
		.connected_i, .overcurrent_i, .reset_done_i, .wakeup_i, .disconnect_i, .chan_halted_i,
		.port_resume_drive_o, .sof_enable_o, .port_enabled_o, .host_port_irq_o, .chan_run_o, .chan_stop_o);
	uhp_dev_model dev (.clk_i, .chan_run_i(chan_run_o), .chan_stop_i(chan_stop_o), .connected_o(connected_i),
		.overcurrent_o(overcurrent_i), .reset_done_o(reset_done_i), .wakeup_o(wakeup_i),
		.disconnect_o(disconnect_i), .chan_halted_o(chan_halted_i));
	// ****
	// tasks
	// ****
	task automatic end_sim();
		if (n_mismatch == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic wr_en, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= wr_en;
		sel_i <= s;
		adr_i <= a;
		dat_i <= d;
		// outputs read right at the edge still hold the values sampled there
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (!(ack_o || err_o) && n < 20);
		if (!(ack_o || err_o))
		begin
			n_mismatch++;
			end_sim();
		end
		else
		begin
			erred = err_o;
			q = dat_o;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
			we_i <= 1'b0;
		end
	endtask : wb
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0, 4'hF);
		chk(q, exp);
	endtask : rc
	task automatic pr(input logic [31:0] exp);
		rc(UHP_OFS_PORT, exp);
	endtask : pr
	task automatic pw(input logic [31:0] d);
		wb(1'b1, UHP_OFS_PORT, d, 4'hF);
	endtask : pw
	task automatic tick(input int c);
		repeat (c) @(negedge clk_i);
	endtask : tick
	// ****
	// sequence
	// ****
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		pr(UHP_RST_PORT);
		rc(UHP_OFS_CHAN0, UHP_RST_CHAN);
		rc(8'h3C, 32'h0);
		chk({31'h0, erred}, 32'h1);
		dev.attach(1'b1, 1'b0);
		tick(10);
		chk({31'h0, host_port_irq_o}, 32'h1);
		pr(32'h3);
		pw(32'h0);
		pr(32'h3);
		pw(32'h6);
		pr(32'h1);
		chk({31'h0, host_port_irq_o}, 32'h0);
		dev.pulse(3'h4);
		pr(32'hD);
		pw(32'h8);
		pr(32'h5);
		pw(32'h4);
		pr(32'h9);
		dev.pulse(3'h4);
		pw(32'h8);
		chk({30'h0, sof_enable_o, port_enabled_o}, 32'h3);
		pw(32'h80);
		pr(32'h85);
		chk({30'h0, sof_enable_o, port_enabled_o}, 32'h1);
		dev.pulse(3'h2);
		pr(32'h45);
		pw(32'h0);
		pr(32'h5);
		pw(32'h40);
		pr(32'h45);
		chk({31'h0, port_resume_drive_o}, 32'h1);
		wb(1'b1, UHP_OFS_PORT, 32'h0, 4'hE);
		pr(32'h45);
		pw(32'h0);
		dev.attach(1'b1, 1'b1);
		tick(10);
		pr(32'h39);
		pw(32'h28);
		pr(32'h11);
		dev.attach(1'b1, 1'b0);
		tick(10);
		pr(32'h21);
		pw(32'h20);
		dev.pulse(3'h4);
		pw(32'h88);
		dev.attach(1'b0, 1'b0);
		dev.pulse(3'h1);
		tick(10);
		pr(32'h88);
		dev.pulse(3'h2);
		pr(32'h48);
		pw(32'h8);
		pr(32'h0);
		dev.attach(1'b1, 1'b0);
		dev.pulse(3'h4);
		tick(10);
		pw(32'hA);
		for (int n = 0; n < UHP_NCHAN; n++)
			wb(1'b1, UHP_OFS_CHAN0 + 8'(4 * n), 32'h3FFF_FFFF ^ (32'(n) * 32'h0040_0801), 4'hF);
		for (int n = 0; n < UHP_NCHAN; n++)
			rc(UHP_OFS_CHAN0 + 8'(4 * n), (32'h3FFF_FFFF ^ (32'(n) * 32'h0040_0801)) & 32'h3FFE_FFFF);
		rc(UHP_OFS_PSTAT, 32'h0000_FFFF);
		// only byte lane 0 may change
		wb(1'b1, UHP_OFS_CHAN0, 32'h0, 4'h1);
		rc(UHP_OFS_CHAN0, 32'h3FFE_FF00);
		// bits 20:18 walk all endpoint types with multi count 0 then 1
		for (int t = 0; t < 8; t++)
		begin
			w = 32'h8000_0000 | (32'(t) << 18);
			wb(1'b1, 8'h44, w, 4'hF);
			tick(2);
			chk({31'h0, chan_run_o[1]}, {31'h0, t[2] | !t[0]});
			wb(1'b1, 8'h44, w | 32'h4000_0000, 4'hF);
			tick(2);
			chk({31'h0, chan_stop_o[1]}, 32'h1);
			tick(30);
			chk({14'h0, chan_run_o, 2'b00} | {16'h0, chan_stop_o}, 32'h0);
			rc(8'h44, w & 32'h3FFF_FFFF);
		end
		end_sim();
	end
endmodule : uhp_regs_test
bind uhp_regs uhp_regs_checker chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o, .err_o, .connected_i,
	.reset_done_i, .wakeup_i, .disconnect_i, .chan_halted_i, .port_resume_drive_o, .sof_enable_o,
	.port_enabled_o, .host_port_irq_o, .chan_run_o, .chan_stop_o);
